// >>> hw/sama_defs.vh
// shared constants for the serial converter addressing and sequencing logic
// assumes inclusion by bare name from each design file of this block
`ifndef SAMA_DEFS_VH
`define SAMA_DEFS_VH

// converter variant codes on the variant strap
`define SAMA_VAR_ONE      2'h0
`define SAMA_VAR_TWO      2'h1
`define SAMA_VAR_EIGHT    2'h2

// address word lengths after the start bit, minus one, per variant
`define SAMA_ALEN_TWO     3'h1
`define SAMA_ALEN_EIGHT   3'h3

// field positions in the shifted word of the eight-channel variant
`define SAMA_W8_MODE      3
`define SAMA_W8_ODD       2
`define SAMA_W8_SEL_HI    1
`define SAMA_W8_SEL_LO    0

// field positions in the shifted word of the two-channel variant
`define SAMA_W2_MODE      1
`define SAMA_W2_ODD       0

// conversion length in serial clock periods, and result bit indices
`define SAMA_CONV_BITS    8
`define SAMA_IDX_MSB      3'h7
`define SAMA_IDX_LSB      3'h0
`define SAMA_IDX_STEP     3'h1

// fixed pair of the single-channel variant
`define SAMA_CH_POS_FIXED 3'h0
`define SAMA_CH_NEG_FIXED 3'h1

// reset and idle values
`define SAMA_RES_ZERO     8'h00
`define SAMA_TRIAL_START  8'h80
`define SAMA_WORD_ZERO    4'h0
`define SAMA_CNT_ZERO     3'h0
`define SAMA_CH_ZERO      3'h0

// synchroniser layout: width and reset levels of the pin inputs
`define SAMA_SYNC_W       8
`define SAMA_SYNC_RST     8'h01

// slot of each pin in the synchroniser bus; chip select resets deselected
`define SAMA_SP_CS        0
`define SAMA_SP_SCLK      1
`define SAMA_SP_DIN       2
`define SAMA_SP_COMP      3
`define SAMA_SP_SE_N      4
`define SAMA_SP_NEG_GE    5
`define SAMA_SP_VAR_LO    6
`define SAMA_SP_VAR_HI    7

// lowest result bit as a mask seed
`define SAMA_BIT_ONE      8'h01

`endif

// >>> hw/sama_sync.v
// two-flop synchronisers for the pin inputs of the converter sequencer
// assumes inputs are asynchronous to the core clock and change slowly
`timescale 1ns/1ps
`include "sama_defs.vh"

module sama_sync #(
  parameter                 WIDTH     = `SAMA_SYNC_W,
  parameter [WIDTH-1:0]     RESET_VAL = `SAMA_SYNC_RST
) (
  // clock and reset
  input  wire               clk_in,
  input  wire               nrst_in,
  // raw and synchronised levels
  input  wire [WIDTH-1:0]   async_in,
  output wire [WIDTH-1:0]   sync_out
);

  reg  [WIDTH-1:0] stage1;
  reg  [WIDTH-1:0] stage2;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      // first stage is read only by the second stage
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          stage1[gi] <= RESET_VAL[gi];
          stage2[gi] <= RESET_VAL[gi];
        end else begin
          stage1[gi] <= async_in[gi];
          stage2[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

// >>> hw/sama_mux_decode.v
// decodes the multiplexer assignment word into positive and negative inputs
// takes the word as it stands after the final address bit, not yet latched; purely combinational
`timescale 1ns/1ps
`include "sama_defs.vh"

module sama_mux_decode (
  // configuration
  input  wire [1:0]  variant_in,
  input  wire [3:0]  word_in,
  // selected inputs
  output reg  [2:0]  pos_ch_out,
  output reg  [2:0]  neg_ch_out,
  output reg         neg_common_out
);

  always @* begin
    pos_ch_out     = `SAMA_CH_POS_FIXED;
    neg_ch_out     = `SAMA_CH_NEG_FIXED;
    neg_common_out = 1'b0;
    case (variant_in)
      `SAMA_VAR_EIGHT: begin
        if (word_in[`SAMA_W8_MODE]) begin
          // channel = select * 2 + odd, common pin always negative
          pos_ch_out     = {word_in[`SAMA_W8_SEL_HI], word_in[`SAMA_W8_SEL_LO],
                            word_in[`SAMA_W8_ODD]};
          neg_ch_out     = `SAMA_CH_ZERO;
          neg_common_out = 1'b1;
        end else begin
          // pair index from select, odd bit picks the positive member
          pos_ch_out = {word_in[`SAMA_W8_SEL_HI], word_in[`SAMA_W8_SEL_LO],
                        word_in[`SAMA_W8_ODD]};
          neg_ch_out = {word_in[`SAMA_W8_SEL_HI], word_in[`SAMA_W8_SEL_LO],
                        ~word_in[`SAMA_W8_ODD]};
        end
      end
      `SAMA_VAR_TWO: begin
        pos_ch_out = {2'h0, word_in[`SAMA_W2_ODD]};
        if (word_in[`SAMA_W2_MODE]) begin
          // single-ended against the grounded common
          neg_ch_out     = `SAMA_CH_ZERO;
          neg_common_out = 1'b1;
        end else begin
          // differential on the only pair, either polarity
          neg_ch_out = {2'h0, ~word_in[`SAMA_W2_ODD]};
        end
      end
      default: begin
        // fixed polarity pair, no word used
        pos_ch_out = `SAMA_CH_POS_FIXED;
        neg_ch_out = `SAMA_CH_NEG_FIXED;
      end
    endcase
  end

endmodule

// >>> hw/sama_top.v
// serial converter sequencer: start bit, address word, settling, result shift-out
// assumes the host drives chip select, serial clock and data-in as pins, and
// an analog core that compares the selected inputs against TRIAL_CODE_OUT
//
// Overview of operation
// - conversion takes exactly eight serial periods
// - convert selected positive minus selected negative input
// - negative at or above positive gives zero
// - differential only within adjacent even/odd pairs
// - word picks which pair member is positive
// - host shifts word in; latched before converting
// - single-channel variant needs no address word
// - eight-channel single-ended: channel select*2+odd
// - eight-channel differential: select pair, odd polarity
// - two-channel: mode picks single-ended or pair
// - eight-channel single-ended negative is common pin
// - rising edges sample; first one is start
// - half-clock settle, flag high, leading zero out
// - MSB first, then LSB first (not on single-channel), then low; eight-channel with shift enable high holds the LSB
// - chip select high clears everything and reloads the variant from the strap
`timescale 1ns/1ps
`include "sama_defs.vh"

module sama_top (
  // clock and reset
  input  wire        CORE_CLK_IN,
  input  wire        NRST_IN,
  // serial link pins from the host
  input  wire        CHIP_SELECT_N_IN,
  input  wire        SERIAL_CLK_IN,
  input  wire        SERIAL_IN_LINE_IN,
  input  wire        LSB_FIRST_SHIFT_ENABLE_N_IN,
  // serial data out pin, driven while enable is high
  output wire        SERIAL_OUT,
  output wire        SERIAL_OUT_EN_OUT,
  // variant strap
  input  wire [1:0]  MUX_VARIANT_IN,
  // analog core interface
  input  wire        COMPARATOR_IN,
  input  wire        NEG_AT_OR_ABOVE_POS_IN,
  output wire [7:0]  TRIAL_CODE_OUT,
  output wire [2:0]  POS_CHANNEL_OUT,
  output wire [2:0]  NEG_CHANNEL_OUT,
  output wire        COMMON_NEGATIVE_PIN_SEL_OUT,
  output wire        MUX_VALID_OUT,
  // status
  output wire        CONVERSION_ACTIVE_FLAG_OUT,
  output wire [7:0]  RESULT_OUT
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_ZERO = 3'h2;
  localparam [2:0] S_MSB  = 3'h3;
  localparam [2:0] S_LSB  = 3'h4;
  localparam [2:0] S_HOLD = 3'h5;

  // synchronised pin levels
  wire [`SAMA_SYNC_W-1:0] sync_bus;
  wire                    cs_n;
  wire                    sclk;
  wire                    din;
  wire                    comp;
  wire                    se_n;
  wire                    neg_ge;
  wire [1:0]              var_pin;

  // every pin has a named slot, so the bus width cannot drift from the map
  wire [`SAMA_SYNC_W-1:0] pin_bus;

  assign pin_bus[`SAMA_SP_CS]     = CHIP_SELECT_N_IN;
  assign pin_bus[`SAMA_SP_SCLK]   = SERIAL_CLK_IN;
  assign pin_bus[`SAMA_SP_DIN]    = SERIAL_IN_LINE_IN;
  assign pin_bus[`SAMA_SP_COMP]   = COMPARATOR_IN;
  assign pin_bus[`SAMA_SP_SE_N]   = LSB_FIRST_SHIFT_ENABLE_N_IN;
  assign pin_bus[`SAMA_SP_NEG_GE] = NEG_AT_OR_ABOVE_POS_IN;
  assign pin_bus[`SAMA_SP_VAR_HI:`SAMA_SP_VAR_LO] = MUX_VARIANT_IN;

  sama_sync #(
    .WIDTH     (`SAMA_SYNC_W),
    .RESET_VAL (`SAMA_SYNC_RST)
  ) u_sync (
    .clk_in   (CORE_CLK_IN),
    .nrst_in  (NRST_IN),
    .async_in (pin_bus),
    .sync_out (sync_bus)
  );

  assign cs_n    = sync_bus[`SAMA_SP_CS];
  assign sclk    = sync_bus[`SAMA_SP_SCLK];
  assign din     = sync_bus[`SAMA_SP_DIN];
  assign comp    = sync_bus[`SAMA_SP_COMP];
  assign se_n    = sync_bus[`SAMA_SP_SE_N];
  assign neg_ge  = sync_bus[`SAMA_SP_NEG_GE];
  assign var_pin = sync_bus[`SAMA_SP_VAR_HI:`SAMA_SP_VAR_LO];

  // sequencer state
  reg  [2:0]  state;
  reg         sclk_prev;
  reg  [1:0]  variant;
  reg  [3:0]  word;
  reg  [2:0]  addr_cnt;
  reg  [2:0]  idx;
  reg  [7:0]  result;
  reg  [7:0]  trial;
  reg         do_bit;
  reg         do_en;
  reg         active;
  reg         mux_valid;
  reg  [2:0]  pos_ch;
  reg  [2:0]  neg_ch;
  reg         neg_com;

  wire        rise = sclk & ~sclk_prev;
  wire        fall = ~sclk & sclk_prev;
  wire [2:0]  alen = (variant == `SAMA_VAR_EIGHT) ? `SAMA_ALEN_EIGHT : `SAMA_ALEN_TWO;
  wire [3:0]  word_shift = {word[2:0], din};
  wire [2:0]  dec_pos;
  wire [2:0]  dec_neg;
  wire        dec_com;
  wire        cmp_bit;
  wire [7:0]  result_upd;
  wire [2:0]  idx_dn = idx - `SAMA_IDX_STEP;
  wire [2:0]  idx_up = idx + `SAMA_IDX_STEP;

  // decodes the word as it will stand after the final address bit
  sama_mux_decode u_dec (
    .variant_in     (variant),
    .word_in        (word_shift),
    .pos_ch_out     (dec_pos),
    .neg_ch_out     (dec_neg),
    .neg_common_out (dec_com)
  );

  // one-hot mask of a result bit position
  function [7:0] bit_mask;
    input [2:0] pos;
    begin
      bit_mask = `SAMA_BIT_ONE << pos;
    end
  endfunction

  // strap codes other than two and eight channels behave as the single-channel part
  function is_single;
    input [1:0] var_code;
    begin
      is_single = (var_code != `SAMA_VAR_TWO) && (var_code != `SAMA_VAR_EIGHT);
    end
  endfunction

  // LSB-first bit advances always on the two-channel part, and on the
  // eight-channel part only while shift enable is held low
  function lsb_advance;
    input [1:0] var_code;
    input       shift_en_n;
    begin
      lsb_advance = (var_code == `SAMA_VAR_TWO) || !shift_en_n;
    end
  endfunction

  // comparator says positive input above ladder; forced low when inverted
  assign cmp_bit    = comp & ~neg_ge;
  assign result_upd = cmp_bit ? (result | bit_mask(idx)) : (result & ~bit_mask(idx));

  // edge detect reads the second synchroniser stage only; a clock parked low
  // between bits simply produces no edge, which is why it may stop there
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk;
    end
  end

  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state     <= S_IDLE;
      variant   <= `SAMA_VAR_ONE;
      word      <= `SAMA_WORD_ZERO;
      addr_cnt  <= `SAMA_CNT_ZERO;
      idx       <= `SAMA_IDX_MSB;
      result    <= `SAMA_RES_ZERO;
      trial     <= `SAMA_TRIAL_START;
      do_bit    <= 1'b0;
      do_en     <= 1'b0;
      active    <= 1'b0;
      mux_valid <= 1'b0;
      pos_ch    <= `SAMA_CH_ZERO;
      neg_ch    <= `SAMA_CH_ZERO;
      neg_com   <= 1'b0;
    end else if (cs_n) begin
      // deselected: clear all, reload variant from the strap; next conversion needs a fresh select and word
      state     <= S_IDLE;
      variant   <= var_pin;
      word      <= `SAMA_WORD_ZERO;
      addr_cnt  <= `SAMA_CNT_ZERO;
      idx       <= `SAMA_IDX_MSB;
      result    <= `SAMA_RES_ZERO;
      trial     <= `SAMA_TRIAL_START;
      do_bit    <= 1'b0;
      do_en     <= 1'b0;
      active    <= 1'b0;
      mux_valid <= 1'b0;
      pos_ch    <= `SAMA_CH_ZERO;
      neg_ch    <= `SAMA_CH_ZERO;
      neg_com   <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (rise) begin
            if (is_single(variant)) begin
              // no start bit or word: fixed pair, settle from the first edge
              pos_ch    <= `SAMA_CH_POS_FIXED;
              neg_ch    <= `SAMA_CH_NEG_FIXED;
              neg_com   <= 1'b0;
              mux_valid <= 1'b1;
              active    <= 1'b1;
              state     <= S_ZERO;
            end else if (din) begin
              // leading zeros ignored, first one is the start bit
              state    <= S_ADDR;
              addr_cnt <= `SAMA_CNT_ZERO;
            end
          end
        end
        S_ADDR: begin
          if (rise) begin
            // word bits shift in on rising edges
            word     <= word_shift;
            addr_cnt <= addr_cnt + `SAMA_IDX_STEP;
            if (addr_cnt == alen) begin
              // configuration latched before conversion; flag up for settling
              pos_ch    <= dec_pos;
              neg_ch    <= dec_neg;
              neg_com   <= dec_com;
              mux_valid <= 1'b1;
              active    <= 1'b1;
              state     <= S_ZERO;
            end
          end
        end
        S_ZERO: begin
          // data-in no longer looked at; leading zero leaves on this falling edge
          if (fall) begin
            do_en  <= 1'b1;
            do_bit <= 1'b0;
            idx    <= `SAMA_IDX_MSB;
            trial  <= `SAMA_TRIAL_START;
            state  <= S_MSB;
          end
        end
        S_MSB: begin
          // one result bit per falling edge, MSB first, eight periods total
          if (fall) begin
            result <= result_upd;
            do_bit <= cmp_bit;
            if (idx == `SAMA_IDX_LSB) begin
              trial <= result_upd;
              state <= S_LSB;
            end else begin
              trial <= result_upd | bit_mask(idx_dn);
              idx   <= idx_dn;
            end
          end
        end
        S_LSB: begin
          // flag drops half a period after the last MSB-first bit
          if (rise) begin
            active <= 1'b0;
          end
          if (fall) begin
            if (is_single(variant) || idx == `SAMA_IDX_MSB) begin
              // single-channel variant has no LSB-first stream
              do_bit <= 1'b0;
              state  <= S_HOLD;
            end else if (lsb_advance(variant, se_n)) begin
              // LSB-first repeat; on the eight-channel part gated by shift enable
              do_bit <= result[idx_up];
              idx    <= idx_up;
            end
          end
        end
        S_HOLD: begin
          // data-out stays low until deselect
          do_bit <= 1'b0;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  assign SERIAL_OUT                  = do_bit;
  assign SERIAL_OUT_EN_OUT           = do_en;
  assign TRIAL_CODE_OUT              = trial;
  assign POS_CHANNEL_OUT             = pos_ch;
  assign NEG_CHANNEL_OUT             = neg_ch;
  assign COMMON_NEGATIVE_PIN_SEL_OUT = neg_com;
  assign MUX_VALID_OUT               = mux_valid;
  assign CONVERSION_ACTIVE_FLAG_OUT  = active;
  assign RESULT_OUT                  = result;

endmodule

// >>> tb/sama_top_sva.sv
// pin-level assertions for the converter sequencer
// assumes all pins are sampled by the core clock; bound into every sama_top
`timescale 1ns/1ps
module sama_top_chk (
  input wire       CORE_CLK_IN,
  input wire       NRST_IN,
  input wire       CHIP_SELECT_N_IN,
  input wire       SERIAL_CLK_IN,
  input wire [1:0] MUX_VARIANT_IN,
  input wire       SERIAL_OUT,
  input wire       SERIAL_OUT_EN_OUT,
  input wire [7:0] TRIAL_CODE_OUT,
  input wire [2:0] POS_CHANNEL_OUT,
  input wire [2:0] NEG_CHANNEL_OUT,
  input wire       COMMON_NEGATIVE_PIN_SEL_OUT,
  input wire       MUX_VALID_OUT,
  input wire       CONVERSION_ACTIVE_FLAG_OUT,
  input wire [7:0] RESULT_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic [1:0] sck;
  logic [3:0] nfall;
  // own edge detector; counts serial falls seen while converting
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sck <= 2'h0;
      nfall <= 4'h0;
    end else begin
      sck <= {sck[0], SERIAL_CLK_IN};
      if (!CONVERSION_ACTIVE_FLAG_OUT)
        nfall <= 4'h0;
      else if (sck == 2'b10)
        nfall <= nfall + 4'h1;
    end
  end
  // six samples covers the pin synchronisers plus the output register
  sequence s_desel;
    CHIP_SELECT_N_IN [*6];
  endsequence
  sequence s_drive_on;
    $rose(SERIAL_OUT_EN_OUT);
  endsequence
  AST_CLR_FLAGS: assert property (s_desel |-> !SERIAL_OUT_EN_OUT && !CONVERSION_ACTIVE_FLAG_OUT)
    else $error("flags not cleared while deselected");
  AST_CLR_DATA: assert property (s_desel |-> !MUX_VALID_OUT && RESULT_OUT == 8'h00
    && TRIAL_CODE_OUT == 8'h80) else $error("data not cleared while deselected");
  AST_LEAD_ZERO: assert property (s_drive_on |-> !SERIAL_OUT && CONVERSION_ACTIVE_FLAG_OUT)
    else $error("no leading zero when output turns on");
  AST_ACT_LATCHED: assert property (CONVERSION_ACTIVE_FLAG_OUT |-> MUX_VALID_OUT)
    else $error("converting without a latched selection");
  AST_MUX_HOLD: assert property (MUX_VALID_OUT && $past(MUX_VALID_OUT) |->
    $stable(POS_CHANNEL_OUT) && $stable(NEG_CHANNEL_OUT) && $stable(COMMON_NEGATIVE_PIN_SEL_OUT))
    else $error("selection changed while latched");
  AST_PAIR: assert property (MUX_VALID_OUT && !COMMON_NEGATIVE_PIN_SEL_OUT |->
    NEG_CHANNEL_OUT == (POS_CHANNEL_OUT ^ 3'h1)) else $error("negative outside the pair");
  AST_COMMON: assert property (MUX_VALID_OUT && COMMON_NEGATIVE_PIN_SEL_OUT |->
    NEG_CHANNEL_OUT == 3'h0 && MUX_VARIANT_IN[0] != MUX_VARIANT_IN[1])
    else $error("bad common selection");
  AST_SINGLE: assert property (MUX_VALID_OUT && MUX_VARIANT_IN[0] == MUX_VARIANT_IN[1]
    |-> POS_CHANNEL_OUT == 3'h0 && NEG_CHANNEL_OUT == 3'h1 && !COMMON_NEGATIVE_PIN_SEL_OUT)
    else $error("bad fixed pair");
  AST_CONV_LEN: assert property ($fell(CONVERSION_ACTIVE_FLAG_OUT) && !CHIP_SELECT_N_IN |->
    nfall == 4'h9) else $error("conversion length wrong");
endmodule
bind sama_top sama_top_chk u_chk (.CORE_CLK_IN, .NRST_IN, .CHIP_SELECT_N_IN, .SERIAL_CLK_IN,
  .MUX_VARIANT_IN, .SERIAL_OUT, .SERIAL_OUT_EN_OUT, .TRIAL_CODE_OUT, .POS_CHANNEL_OUT,
  .NEG_CHANNEL_OUT, .COMMON_NEGATIVE_PIN_SEL_OUT, .MUX_VALID_OUT, .CONVERSION_ACTIVE_FLAG_OUT,
  .RESULT_OUT);

// >>> tb/sama_host_model.sv
// host model: chip select, serial clock and data-in; samples data-out
// assumes it is paced by the core clock, half period of eight core clocks
`timescale 1ns/1ps
module sama_host_model (
  input  wire  clk_in,
  input  wire  so_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic di_out
);
  logic rx [0:31];
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    di_out = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // data-out is read just before each rise, well after the fall that set it
  task automatic xfer(input logic [31:0] pat, input int np);
    cs_n_out = 1'b0;
    step(8);
    for (int k = 0; k < np; k++) begin
      di_out = pat[k];
      step(8);
      rx[k] = so_in;
      sclk_out = 1'b1;
      step(8);
      sclk_out = 1'b0;
    end
  endtask
  task automatic desel;
    cs_n_out = 1'b1;
    di_out = 1'b0;
    step(8);
  endtask
endmodule

// >>> tb/sama_tb_top.sv
// self-checking bench: host model, analog core model, scenario tasks
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module sama_tb_top;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       se_n = 1'b0;
  logic [1:0] vsel = 2'h2;
  logic [7:0] v [0:8];
  logic       cs_n, sclk, di, so, so_en, valid, common_negative_pin, act;
  logic [7:0] trial, res, vn;
  logic [2:0] pos, neg;
  int         fails = 0;
  int         cmp_count = 0;
  initial forever #2.5 clk = ~clk;
  // index 8 is the common pin; a released data-out reads inverted
  assign vn = common_negative_pin ? v[8] : v[neg];
  sama_top uut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .CHIP_SELECT_N_IN(cs_n),
    .SERIAL_CLK_IN(sclk), .SERIAL_IN_LINE_IN(di), .LSB_FIRST_SHIFT_ENABLE_N_IN(se_n),
    .SERIAL_OUT(so), .SERIAL_OUT_EN_OUT(so_en), .MUX_VARIANT_IN(vsel),
    .COMPARATOR_IN(v[pos] - vn >= trial), .NEG_AT_OR_ABOVE_POS_IN(vn >= v[pos]),
    .TRIAL_CODE_OUT(trial), .POS_CHANNEL_OUT(pos), .NEG_CHANNEL_OUT(neg),
    .COMMON_NEGATIVE_PIN_SEL_OUT(common_negative_pin), .MUX_VALID_OUT(valid),
    .CONVERSION_ACTIVE_FLAG_OUT(act), .RESULT_OUT(res));
  sama_host_model host (.clk_in(clk), .so_in(so_en ? so : ~so), .cs_n_out(cs_n),
    .sclk_out(sclk), .di_out(di));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // two idle zeros, start bit, word MSB first, then ones that must be ignored
  function automatic logic [31:0] mkpat(input logic [3:0] w, input int nw);
    logic [31:0] p;
    p = 32'hffff_fffc;
    for (int i = 0; i < nw; i++)
      p[3 + i] = w[nw - 1 - i];
    return p;
  endfunction
  task automatic conv(input logic [1:0] vr, input logic [3:0] w, input int nw, input logic hold);
    logic [2:0] ep, en;
    logic       ec, e, sg;
    logic [7:0] code;
    int         l;
    vsel = vr;
    sg = (vr == 2'h0 || vr == 2'h3);
    host.step(4);
    ep = (vr == 2'h2) ? {w[1:0], w[2]} : (vr == 2'h1) ? {2'h0, w[0]} : 3'h0;
    ec = (vr == 2'h2) ? w[3] : (vr == 2'h1) ? w[1] : 1'b0;
    en = ec ? 3'h0 : sg ? 3'h1 : ep ^ 3'h1;
    code = ((ec ? v[8] : v[en]) >= v[ep]) ? 8'h00 : v[ep] - (ec ? v[8] : v[en]);
    l = sg ? 0 : 2 + nw;
    host.xfer(mkpat(w, nw), l + 19);
    chk("pos", {5'h0, ep}, {5'h0, pos});
    chk("neg", {5'h0, en}, {5'h0, neg});
    chk("common", {7'h0, ec}, {7'h0, common_negative_pin});
    chk("valid_active", 8'h2, {6'h0, valid, act});
    chk("result", code, res);
    for (int k = 0; k < 18; k++) begin
      if (k == 0)
        e = 1'b0;
      else if (k < 9)
        e = code[8 - k];
      else if (hold)
        e = code[0];
      else if (k < 16 && !sg)
        e = code[k - 8];
      else
        e = 1'b0;
      chk("data_out", {7'h0, e}, {7'h0, host.rx[l + 1 + k]});
    end
    host.desel();
  endtask
  task automatic t_abort;
    vsel = 2'h2;
    host.xfer(mkpat(4'h9, 4), 10);
    host.desel();
    chk("cleared", 8'h0, {5'h0, valid, act, so_en});
    chk("result_clr", 8'h0, res);
    conv(2'h2, 4'h9, 4, 1'b0);
  endtask
  task automatic t_eight;
    for (int w = 0; w < 16; w++)
      conv(2'h2, 4'(w), 4, 1'b0);
  endtask
  task automatic t_two;
    for (int w = 0; w < 4; w++)
      conv(2'h1, 4'(w), 2, 1'b0);
  endtask
  task automatic t_one;
    v[0] = 8'hc5;
    conv(2'h0, 4'h0, 0, 1'b0);
    conv(2'h3, 4'h0, 0, 1'b0);
    v[0] = 8'h07;
  endtask
  task automatic t_hold;
    se_n = 1'b1;
    conv(2'h2, 4'hb, 4, 1'b1);
    se_n = 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 8; i++)
      v[i] = 8'(24 * i + 7);
    v[8] = 8'h04;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    host.step(4);
    t_abort();
    t_eight();
    t_two();
    t_one();
    t_hold();
    end_sim();
  end
endmodule
